// *** hdl/dpdc_top.sv ***
// Behaviour
// - 16-bit control at 98h, resets to 2000h
// - Bit 15 reserved, reads zero
// - Bits 14:12 read request size code
// - Read fetch bounded by limit and line
// - No-snoop enable bit reads zero
// - Aux power PM enable reads zero
// - Phantom function enable reads zero
// - Extended tag enable reads zero
// - Bits 7:5 payload size code, bounds writes
// - Relaxed ordering enable reads zero
// - Unsupported request reported as nonfatal when enabled
// - Fatal error message sent when enabled
// - Nonfatal error message sent when enabled
// - Correctable error message sent when enabled
// - Errors logged in status whatever enables say
`default_nettype none
module dpdc_top (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire dpdc_pkg::dpdc_cfg_req_type cfg_req_i,
  output dpdc_pkg::dpdc_cfg_rsp_type      cfg_rsp_o,
  input  wire logic [7:0]                 cache_line_size_i,
  input  wire logic                       correctable_event_i,
  input  wire logic                       nonfatal_event_i,
  input  wire logic                       fatal_event_i,
  input  wire logic                       unsupported_request_i,
  output logic                            err_corr_msg_o,
  output logic                            err_nonfatal_msg_o,
  output logic                            err_fatal_msg_o,
  output logic [12:0]                     read_fetch_bytes_o,
  output logic [12:0]                     payload_max_bytes_o,
  output dpdc_pkg::dpdc_ctrl_type         ctrl_o
);

  dpdc_pkg::dpdc_ctrl_type    ctrl_ff;
  dpdc_pkg::dpdc_cfg_rsp_type rsp_ff;
  logic                       err_corr_ff;
  logic                       err_nf_ff;
  logic                       err_fat_ff;
  logic [12:0]                fetch_ff;
  logic [12:0]                payload_ff;

  logic                         hit_dword;
  logic                         wr_lo;
  logic                         wr_hi;
  logic                         wr_stat;
  logic [15:0]                  ctrl_word;
  logic [dpdc_pkg::ERR_NUM-1:0] events;
  logic [dpdc_pkg::ERR_NUM-1:0] enables;
  logic [dpdc_pkg::ERR_NUM-1:0] clears;
  logic [dpdc_pkg::ERR_NUM-1:0] msg_req;
  logic [dpdc_pkg::ERR_NUM-1:0] detected;
  logic [12:0]                  rrs_bytes;
  logic [12:0]                  line_bytes;

  function automatic logic [12:0] size_bytes(input logic [2:0] code);
    if (code > dpdc_pkg::SIZE_CODE_MAX) begin
      size_bytes = dpdc_pkg::SIZE_BASE_BYTES;
    end else begin
      size_bytes = dpdc_pkg::SIZE_BASE_BYTES << code;
    end
  endfunction : size_bytes

  assign hit_dword = cfg_req_i.valid && (cfg_req_i.addr[11:2] == dpdc_pkg::DEV_CTRL_OFFSET[11:2]);
  assign wr_lo     = hit_dword && cfg_req_i.we && cfg_req_i.be[0];
  assign wr_hi     = hit_dword && cfg_req_i.we && cfg_req_i.be[1];
  assign wr_stat   = hit_dword && cfg_req_i.we && cfg_req_i.be[2];

  // Hardwired zeros at 15, 11..8 and 4
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[dpdc_pkg::RRS_LSB +: 3] = ctrl_ff.read_request_size_limit;
    ctrl_word[dpdc_pkg::PLS_LSB +: 3] = ctrl_ff.payload_size_limit;
    ctrl_word[dpdc_pkg::UR_EN_BIT]    = ctrl_ff.unsupported_request_report_enable;
    ctrl_word[dpdc_pkg::FAT_EN_BIT]   = ctrl_ff.fatal_report_enable;
    ctrl_word[dpdc_pkg::NF_EN_BIT]    = ctrl_ff.nonfatal_report_enable;
    ctrl_word[dpdc_pkg::COR_EN_BIT]   = ctrl_ff.correctable_report_enable;
  end

  // Only writable fields are stored
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_ff.read_request_size_limit           <= dpdc_pkg::RRS_RESET;
      ctrl_ff.payload_size_limit                <= dpdc_pkg::PLS_RESET;
      ctrl_ff.unsupported_request_report_enable <= 1'b0;
      ctrl_ff.fatal_report_enable               <= 1'b0;
      ctrl_ff.nonfatal_report_enable            <= 1'b0;
      ctrl_ff.correctable_report_enable         <= 1'b0;
    end else begin
      if (wr_hi) begin
        ctrl_ff.read_request_size_limit <= cfg_req_i.wdata[dpdc_pkg::RRS_LSB +: 3];
      end
      if (wr_lo) begin
        ctrl_ff.payload_size_limit <= cfg_req_i.wdata[dpdc_pkg::PLS_LSB +: 3];
        ctrl_ff.unsupported_request_report_enable <= cfg_req_i.wdata[dpdc_pkg::UR_EN_BIT];
        ctrl_ff.fatal_report_enable       <= cfg_req_i.wdata[dpdc_pkg::FAT_EN_BIT];
        ctrl_ff.nonfatal_report_enable    <= cfg_req_i.wdata[dpdc_pkg::NF_EN_BIT];
        ctrl_ff.correctable_report_enable <= cfg_req_i.wdata[dpdc_pkg::COR_EN_BIT];
      end
    end
  end

  // Status flags, write one to clear
  assign events  = {unsupported_request_i, fatal_event_i, nonfatal_event_i, correctable_event_i};
  assign enables = {ctrl_ff.unsupported_request_report_enable, ctrl_ff.fatal_report_enable,
                    ctrl_ff.nonfatal_report_enable, ctrl_ff.correctable_report_enable};
  assign clears  = wr_stat ? cfg_req_i.wdata[dpdc_pkg::STATUS_LSB +: dpdc_pkg::ERR_NUM]
                           : {dpdc_pkg::ERR_NUM{1'b0}};

  for (genvar g = 0; g < dpdc_pkg::ERR_NUM; g++) begin : g_err
    dpdc_err_channel u_chan (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .event_i     (events[g]),
      .report_en_i (enables[g]),
      .clear_i     (clears[g]),
      .msg_req_o   (msg_req[g]),
      .detected_o  (detected[g])
    );
  end

  // Error messages toward the root complex
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      err_corr_ff <= 1'b0;
      err_nf_ff   <= 1'b0;
      err_fat_ff  <= 1'b0;
    end else begin
      err_corr_ff <= msg_req[dpdc_pkg::ERR_COR];
      err_fat_ff  <= msg_req[dpdc_pkg::ERR_FAT];
      err_nf_ff   <= msg_req[dpdc_pkg::ERR_NF] | msg_req[dpdc_pkg::ERR_UR];
    end
  end

  // Config read answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.ack <= cfg_req_i.valid;
      if (cfg_req_i.valid && !cfg_req_i.we && hit_dword) begin
        rsp_ff.rdata <= {12'h000, detected, ctrl_word};
      end else begin
        rsp_ff.rdata <= 32'h0000_0000;
      end
    end
  end

  // Size limits in bytes for the transaction engines
  assign rrs_bytes  = size_bytes(ctrl_ff.read_request_size_limit);
  assign line_bytes = {3'h0, cache_line_size_i, 2'h0};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fetch_ff   <= dpdc_pkg::SIZE_BASE_BYTES << dpdc_pkg::RRS_RESET;
      payload_ff <= dpdc_pkg::SIZE_BASE_BYTES;
    end else begin
      if ((line_bytes != 13'h0000) && (line_bytes < rrs_bytes)) begin
        fetch_ff <= line_bytes;
      end else begin
        fetch_ff <= rrs_bytes;
      end
      payload_ff <= size_bytes(ctrl_ff.payload_size_limit);
    end
  end

  assign cfg_rsp_o           = rsp_ff;
  assign err_corr_msg_o      = err_corr_ff;
  assign err_nonfatal_msg_o  = err_nf_ff;
  assign err_fatal_msg_o     = err_fat_ff;
  assign read_fetch_bytes_o  = fetch_ff;
  assign payload_max_bytes_o = payload_ff;
  assign ctrl_o              = ctrl_ff;

endmodule : dpdc_top
`default_nettype wire

// *** hdl/dpdc_pkg.sv ***
`default_nettype none
package dpdc_pkg;

  localparam logic [11:0] DEV_CTRL_OFFSET   = 12'h098;
  localparam logic [11:0] DEV_STATUS_OFFSET = 12'h09A;
  localparam logic [15:0] DEV_CTRL_RESET    = 16'h2000;

  // Field positions inside the control word; status flags start at dword bit 16
  localparam int RRS_LSB    = 12;
  localparam int PLS_LSB    = 5;
  localparam int UR_EN_BIT  = 3;
  localparam int FAT_EN_BIT = 2;
  localparam int NF_EN_BIT  = 1;
  localparam int COR_EN_BIT = 0;
  localparam int STATUS_LSB = 16;

  localparam logic [2:0] RRS_RESET = 3'h2;
  localparam logic [2:0] PLS_RESET = 3'h0;

  // Size codes 0 to 5: 128 bytes shifted left by the code; codes 6 and 7 give 128 bytes
  localparam logic [12:0] SIZE_BASE_BYTES = 13'h0080;
  localparam logic [2:0]  SIZE_CODE_MAX   = 3'h5;

  // Error classes in the status word
  localparam int ERR_COR = 0;
  localparam int ERR_NF  = 1;
  localparam int ERR_FAT = 2;
  localparam int ERR_UR  = 3;
  localparam int ERR_NUM = 4;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } dpdc_cfg_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } dpdc_cfg_rsp_type;

  typedef struct packed {
    logic [2:0] read_request_size_limit;
    logic [2:0] payload_size_limit;
    logic       unsupported_request_report_enable;
    logic       fatal_report_enable;
    logic       nonfatal_report_enable;
    logic       correctable_report_enable;
  } dpdc_ctrl_type;

endpackage : dpdc_pkg
`default_nettype wire

// *** hdl/dpdc_err_channel.sv ***
`default_nettype none
// One error class: sticky detected flag and gated message request
module dpdc_err_channel (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic event_i,
  input  wire logic report_en_i,
  input  wire logic clear_i,
  output logic      msg_req_o,
  output logic      detected_o
);

  logic detected_ff;

  // Logged regardless of enable; set beats clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      detected_ff <= 1'b0;
    end else if (event_i) begin
      detected_ff <= 1'b1;
    end else if (clear_i) begin
      detected_ff <= 1'b0;
    end
  end

  assign msg_req_o  = event_i & report_en_i;
  assign detected_o = detected_ff;

endmodule : dpdc_err_channel
`default_nettype wire

// *** sim/dpdc_top_sva.sv ***
`default_nettype none
module dpdc_checker (
  input wire logic                       clk_i,
  input wire logic                       resetn_i,
  input wire dpdc_pkg::dpdc_cfg_req_type cfg_req_i,
  input wire dpdc_pkg::dpdc_cfg_rsp_type cfg_rsp_o,
  input wire logic [7:0]                 cache_line_size_i,
  input wire logic                       correctable_event_i,
  input wire logic                       nonfatal_event_i,
  input wire logic                       fatal_event_i,
  input wire logic                       unsupported_request_i,
  input wire logic                       err_corr_msg_o,
  input wire logic                       err_nonfatal_msg_o,
  input wire logic                       err_fatal_msg_o,
  input wire logic [12:0]                read_fetch_bytes_o,
  input wire logic [12:0]                payload_max_bytes_o,
  input wire dpdc_pkg::dpdc_ctrl_type    ctrl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  function automatic logic [12:0] sz(input logic [2:0] c);
    return (c > 3'h5) ? 13'h0080 : 13'h0080 << c;
  endfunction : sz
  chk_ack_next:
    assert property (cfg_req_i.valid |=> cfg_rsp_o.ack) else $error("ack missing");
  chk_ro_zero:
    assert property (cfg_rsp_o.ack |-> (cfg_rsp_o.rdata & 32'hFFF08F10) == 32'h0)
    else $error("read-only bit set");
  chk_field_back:
    assert property (cfg_req_i.valid && !cfg_req_i.we && cfg_req_i.addr == 12'h098 |=>
      {cfg_rsp_o.rdata[14:12], cfg_rsp_o.rdata[7:5], cfg_rsp_o.rdata[3:0]} == $past(ctrl_o))
    else $error("field readback");
  chk_corr_msg:
    assert property ($past(resetn_i) |-> err_corr_msg_o == $past(correctable_event_i & ctrl_o[0]))
    else $error("correctable message");
  chk_fatal_msg:
    assert property ($past(resetn_i) |-> err_fatal_msg_o == $past(fatal_event_i & ctrl_o[2]))
    else $error("fatal message");
  chk_nf_msg:
    assert property ($past(resetn_i) |-> err_nonfatal_msg_o ==
      $past(nonfatal_event_i & ctrl_o[1] | unsupported_request_i & ctrl_o[3]))
    else $error("nonfatal message");
  chk_pay_size:
    assert property ($past(resetn_i) |-> payload_max_bytes_o == sz($past(ctrl_o[6:4])))
    else $error("payload size");
  chk_fetch_cap:
    assert property ($past(resetn_i) && cache_line_size_i == 8'h00 |=>
      read_fetch_bytes_o == sz($past(ctrl_o[9:7]))) else $error("fetch size");
  chk_fetch_line:
    assert property ($past(resetn_i) && cache_line_size_i != 8'h00 |=>
      read_fetch_bytes_o <= {3'h0, $past(cache_line_size_i), 2'h0} &&
      read_fetch_bytes_o <= sz($past(ctrl_o[9:7]))) else $error("fetch above line");
  cov_fatal: cover property (err_fatal_msg_o);
  cov_ur_rep: cover property (unsupported_request_i && ctrl_o[3]);
  cov_flags: cover property (cfg_rsp_o.ack && cfg_rsp_o.rdata[19:16] != 4'h0);
endmodule : dpdc_checker
bind dpdc_top dpdc_checker dpdc_checker_i (.*);
`default_nettype wire

// *** sim/dpdc_host_model.sv ***
`default_nettype none
module dpdc_host_model (
  input  wire logic                       clk_i,
  input  wire dpdc_pkg::dpdc_cfg_rsp_type cfg_rsp_i,
  output var dpdc_pkg::dpdc_cfg_req_type  cfg_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cfg_req_o = '0;
  task automatic access(input logic w, input logic [11:0] a, input logic [3:0] b,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cfg_req_o <= '{1'b1, w, a, b, d};
    @(posedge clk_i);
    // Released lines show inverted junk
    cfg_req_o <= '{1'b0, ~w, ~a, ~b, ~d};
    do @(posedge clk_i); while (cfg_rsp_i.ack !== 1'b1 && ++n < 8);
    // Missing answer counts against the run
    if (n >= 8) dpdc_top_tb.n_mismatch++;
    q = cfg_rsp_i.rdata;
  endtask : access
endmodule : dpdc_host_model
`default_nettype wire

// *** sim/dpdc_top_tb.sv ***
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module dpdc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clk_i, resetn_i, err_corr_msg_o, err_nonfatal_msg_o;
  logic                       correctable_event_i, nonfatal_event_i, fatal_event_i;
  logic                       unsupported_request_i, err_fatal_msg_o;
  logic [7:0]                 cache_line_size_i;
  logic [12:0]                read_fetch_bytes_o, payload_max_bytes_o;
  logic [31:0]                q, wd;
  int                         n_mismatch, comparisons, seed, i, cyc = 0;
  dpdc_pkg::dpdc_cfg_req_type cfg_req_i;
  dpdc_pkg::dpdc_cfg_rsp_type cfg_rsp_o;
  dpdc_pkg::dpdc_ctrl_type    ctrl_o;
  dpdc_top dpdc_top_i (.*);
  dpdc_host_model dpdc_host_model_i (.clk_i(clk_i), .cfg_rsp_i(cfg_rsp_o), .cfg_req_o(cfg_req_i));
  function automatic logic [12:0] sz(input logic [2:0] c);
    return 13'h0080 << c;
  endfunction : sz
  function automatic logic [12:0] fetch_exp(input logic [2:0] c, input logic [7:0] l);
    logic [12:0] lb;
    lb = {3'h0, l, 2'h0};
    return (lb != 13'h0000 && lb < sz(c)) ? lb : sz(c);
  endfunction : fetch_exp
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    seed = 32'h9af1;
    {resetn_i, correctable_event_i, nonfatal_event_i, fatal_event_i} = '0;
    {unsupported_request_i, cache_line_size_i, n_mismatch, comparisons} = '0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    dpdc_host_model_i.access(1'b0, 12'h098, 4'hF, 32'h0, q);
    `CHK(q, 32'h00002000)
    dpdc_host_model_i.access(1'b1, 12'h098, 4'hF, 32'hFFF0DFBF, q);
    dpdc_host_model_i.access(1'b1, 12'h0A0, 4'hF, 32'h0, q);
    dpdc_host_model_i.access(1'b0, 12'h0A0, 4'hF, 32'h0, q);
    `CHK(q, 32'h0)
    dpdc_host_model_i.access(1'b0, 12'h098, 4'hF, 32'h0, q);
    `CHK(q, 32'h000050AF)
    `CHK(payload_max_bytes_o, 13'h1000)
    `CHK(read_fetch_bytes_o, 13'h1000)
    for (i = 0; i < 24; i++) begin
      wd = $random(seed);
      wd[14:12] = wd[14:12] % 3'h6;
      wd[7:5] = wd[7:5] % 3'h6;
      wd[19:16] = 4'h0;
      cache_line_size_i <= wd[31:24];
      dpdc_host_model_i.access(1'b1, 12'h098, 4'hF, wd, q);
      dpdc_host_model_i.access(1'b0, 12'h098, 4'hF, 32'h0, q);
      `CHK(q, {16'h0, wd[15:0] & 16'h70EF})
      `CHK(payload_max_bytes_o, sz(wd[7:5]))
      `CHK(read_fetch_bytes_o, fetch_exp(wd[14:12], wd[31:24]))
      {unsupported_request_i, fatal_event_i, nonfatal_event_i, correctable_event_i} <= wd[23:20];
      @(posedge clk_i);
      {unsupported_request_i, fatal_event_i, nonfatal_event_i, correctable_event_i} <= 4'h0;
      @(posedge clk_i);
      `CHK(err_fatal_msg_o, wd[22] & wd[2])
      `CHK(err_nonfatal_msg_o, wd[21] & wd[1] | wd[23] & wd[3])
      `CHK(err_corr_msg_o, wd[20] & wd[0])
      dpdc_host_model_i.access(1'b0, 12'h098, 4'hF, 32'h0, q);
      `CHK(q[19:16], wd[23:20])
      dpdc_host_model_i.access(1'b1, 12'h098, 4'h4, 32'h000F0000, q);
    end
    // Event lands on the same edge as the flag clear
    fork
      dpdc_host_model_i.access(1'b1, 12'h098, 4'h4, 32'h000F0000, q);
      begin
        @(posedge clk_i);
        correctable_event_i <= 1'b1;
        @(posedge clk_i);
        correctable_event_i <= 1'b0;
      end
    join
    dpdc_host_model_i.access(1'b0, 12'h098, 4'hF, 32'h0, q);
    `CHK(q[19:16], 4'h1)
    // Mid-run reset restores defaults and drops flags
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    dpdc_host_model_i.access(1'b0, 12'h098, 4'hF, 32'h0, q);
    `CHK(q, 32'h00002000)
    `CHK(payload_max_bytes_o, 13'h0080)
    complete_run();
  end
endmodule : dpdc_top_tb
`default_nettype wire
